/* File: include/sacp_pkg.sv */
// Shared constants and types of the serial converter sequencer.
package sacp_pkg;
    // ------------------------------------------------------------
    // Resolution variants
    // ------------------------------------------------------------
    localparam logic [1:0] VAR_12 = 2'h0;
    localparam logic [1:0] VAR_10 = 2'h1;
    localparam logic [1:0] VAR_8 = 2'h2;

    // ------------------------------------------------------------
    // Frame counts of falling serial clock edges
    // ------------------------------------------------------------
    localparam logic [4:0] EDGES_12 = 5'h10;
    localparam logic [4:0] EDGES_10 = 5'h0e;
    localparam logic [4:0] EDGES_8 = 5'h0c;
    localparam logic [4:0] HOLD_EDGE = 5'h03;
    localparam logic [4:0] EDGE_ONE = 5'h01;
    localparam logic [4:0] EDGE_ZERO = 5'h00;

    // ------------------------------------------------------------
    // Result word layout and buffer depth
    // ------------------------------------------------------------
    localparam int RES_W = 12;
    localparam int RES_W_10 = 10;
    localparam int RES_W_8 = 8;
    localparam int WORD_W = 16;
    localparam logic [3:0] LEAD_ZEROS = 4'h0;
    localparam logic [1:0] PAD_10 = 2'h0;
    localparam logic [3:0] PAD_8 = 4'h0;
    localparam logic [RES_W-1:0] RES_ZERO = 12'h000;
    localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
    localparam int FIFO_DEPTH = 8;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_POWER_DOWN,
        ST_TRACK,
        ST_CONVERT
    } sacp_state_t;
endpackage : sacp_pkg

/* File: hw/sacp_fifo.sv */
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module sacp_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);
    localparam logic [AW:0] CNT_ONE = (AW+1)'(1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_reg;
    logic [AW-1:0] rdPtr_reg;
    logic [AW:0] count_reg;
    logic [AW:0] count_next;
    wire doWrite = inValid && inReady;
    wire doRead = outValid && outReady;

    // Occupancy after this cycle's accept and drain.
    assign count_next = (doWrite && !doRead) ? count_reg + CNT_ONE :
                        (doRead && !doWrite) ? count_reg - CNT_ONE : count_reg;
    // Ready is registered from the next count, so it leaves through a flop without extra latency.
    assign outValid = (count_reg != '0);
    assign outData = mem[rdPtr_reg];

    // Storage is not reset; only the pointers, the count and the ready flop carry control state.
    always_ff @(posedge clk) begin
        if (doWrite) begin
            mem[wrPtr_reg] <= inData;
        end
    end

    // Pointers wrap naturally because the depth is a power of two.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
            inReady <= 1'b1;
        end else begin
            if (doWrite) wrPtr_reg <= wrPtr_reg + AW'(1);
            if (doRead) rdPtr_reg <= rdPtr_reg + AW'(1);
            count_reg <= count_next;
            inReady <= (count_next != DEPTH_CNT);
        end
    end
endmodule : sacp_fifo

/* File: hw/sacp_sequencer.sv */
// Conversion and power sequencer of a serial-output sampling converter.
// Notes on behaviour
// - Power-down is entered automatically when a conversion finishes.
// - Chip select falling starts power-up, track mode and a new conversion.
// - In power-down the track-and-hold stays in hold.
// - Hold returns on the third falling serial clock edge after select.
// - 12-bit variant: 16 clocks per frame, power-down on 16th falling edge.
// - 10-bit variant: 14 clocks per frame, power-down on 14th falling edge.
// - 8-bit variant: 12 clocks per frame, power-down on 12th falling edge.
// - Select rising early aborts, tri-states output and powers down.
// - Conversion length is set only by the serial clock count.
// - Word is four leading zeros then result, MSB first.
// - Select falling enables output with the first leading zero.
// - Each later bit shifts out on successive falling clock edges.
// - 12-bit: last bit driven on 15th edge, valid at 16th.
`timescale 1ns/100ps
module sacp_sequencer (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Variant strap and sample source
    input wire logic [1:0] variantSel,
    input wire logic sampleValid,
    output logic sampleReady,
    input wire logic [11:0] sampleData,
    // Serial link pins
    input wire logic chipSelectN,
    input wire logic serialClk,
    output logic serialResultOut,
    output logic serialResultOeN,
    // Analog control and frame status
    output logic trackMode,
    output logic poweredUp,
    output logic frameDone
);
    // ------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------
    logic csMeta_reg;
    logic csSync_reg;
    logic csLast_reg;
    logic sclkMeta_reg;
    logic sclkSync_reg;
    logic sclkLast_reg;

    // Three flops per pin; only the second stage and later are read.
    // The third stage keeps last cycle's settled level for edge detection.
    // Reset values match the idle pins, select high and clock low, so the
    // release of reset can never be mistaken for a select or clock edge.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            csMeta_reg <= 1'b1;
            csSync_reg <= 1'b1;
            csLast_reg <= 1'b1;
            sclkMeta_reg <= 1'b0;
            sclkSync_reg <= 1'b0;
            sclkLast_reg <= 1'b0;
        end else begin
            csMeta_reg <= chipSelectN;
            csSync_reg <= csMeta_reg;
            csLast_reg <= csSync_reg;
            sclkMeta_reg <= serialClk;
            sclkSync_reg <= sclkMeta_reg;
            sclkLast_reg <= sclkSync_reg;
        end
    end

    wire csFall = csLast_reg && !csSync_reg;
    wire csRise = !csLast_reg && csSync_reg;
    wire sclkFall = sclkLast_reg && !sclkSync_reg;
    // Edges are seen two system clocks after the pin moves. The link clock
    // must therefore stay high and low for several system clocks each; a
    // faster link clock would have its edges merged or lost by the samplers.

    // ------------------------------------------------------------
    // Variant decode
    // ------------------------------------------------------------
    logic [1:0] variant_reg;
    // Strap value three is not a variant of its own and falls back to 12 bits.
    wire [4:0] frameEdges = (variant_reg == sacp_pkg::VAR_8) ? sacp_pkg::EDGES_8 :
                            (variant_reg == sacp_pkg::VAR_10) ? sacp_pkg::EDGES_10 :
                            sacp_pkg::EDGES_12;
    wire [15:0] fifoWord;
    wire fifoValid;
    // Result is left aligned after the zeros; unused tail bits are zero.
    // The narrow variants end their frame before the padding is reached, so
    // the padding never shows on the pin in a complete frame.
    wire [15:0] wordLoad = (variant_reg == sacp_pkg::VAR_8) ?
                           {sacp_pkg::LEAD_ZEROS, fifoWord[sacp_pkg::RES_W_8-1:0], sacp_pkg::PAD_8} :
                           (variant_reg == sacp_pkg::VAR_10) ?
                           {sacp_pkg::LEAD_ZEROS, fifoWord[sacp_pkg::RES_W_10-1:0], sacp_pkg::PAD_10} :
                           {sacp_pkg::LEAD_ZEROS, fifoWord[sacp_pkg::RES_W-1:0]};

    // ------------------------------------------------------------
    // Result buffering
    // ------------------------------------------------------------
    // Samples are stored already prefixed with the leading zeros, so the word
    // popped at frame start needs only the variant's alignment.
    logic fifoPop;
    sacp_fifo #(
        .WIDTH(sacp_pkg::WORD_W),
        .DEPTH(sacp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .inValid(sampleValid),
        .inReady(sampleReady),
        .inData({sacp_pkg::LEAD_ZEROS, sampleData}),
        .outValid(fifoValid),
        .outReady(fifoPop),
        .outData(fifoWord)
    );

    // ------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------
    // The frame runs power-down, track, convert and back to power-down.
    // Track ends at the hold edge or an early rise; convert ends at the last edge or an early rise.
    sacp_pkg::sacp_state_t state_reg;
    sacp_pkg::sacp_state_t state_next;
    logic [4:0] edgeCnt_reg;
    logic [15:0] shift_reg;
    // Bit positions of the output shifter, taken from the word width.
    localparam int WORD_MSB = sacp_pkg::WORD_W - 1;
    localparam int NEXT_MSB = sacp_pkg::WORD_W - 2;

    // The counter holds the edges already seen, so the arriving edge is one more.
    wire lastEdge = sclkFall && ((edgeCnt_reg + sacp_pkg::EDGE_ONE) == frameEdges);
    wire holdEdge = sclkFall && ((edgeCnt_reg + sacp_pkg::EDGE_ONE) == sacp_pkg::HOLD_EDGE);
    // Anything but power-down counts as inside a frame.
    wire inFrame = (state_reg != sacp_pkg::ST_POWER_DOWN);

    // A word is popped at the start of each frame; an empty buffer sends zeros.
    // Popping on the select edge fixes the word before any bit leaves.
    assign fifoPop = csFall && fifoValid;

    // Next state: select edges win over clock edges so an abort is never lost.
    // A select fall inside a frame only reloads counter and word; the state
    // stays where it is, which keeps the sequencer from flipping back to track.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            sacp_pkg::ST_POWER_DOWN: begin
                if (csFall) state_next = sacp_pkg::ST_TRACK;
            end
            sacp_pkg::ST_TRACK: begin
                if (csRise) state_next = sacp_pkg::ST_POWER_DOWN;
                else if (holdEdge) state_next = sacp_pkg::ST_CONVERT;
            end
            sacp_pkg::ST_CONVERT: begin
                if (csRise) state_next = sacp_pkg::ST_POWER_DOWN;
                else if (lastEdge) state_next = sacp_pkg::ST_POWER_DOWN;
            end
            // An illegal state code falls back to power-down, the safe state.
            default: state_next = sacp_pkg::ST_POWER_DOWN;
        endcase
    end

    // Variant follows the strap while powered down and freezes at frame start, so a change never splits a frame.
    // The capture pauses in the select-fall cycle, because that cycle already
    // loads the word with the variant held so far.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= sacp_pkg::ST_POWER_DOWN;
            variant_reg <= sacp_pkg::VAR_12;
        end else begin
            state_reg <= state_next;
            if (state_reg == sacp_pkg::ST_POWER_DOWN && !csFall) variant_reg <= variantSel;
        end
    end

    // Counter of falling edges, cleared by the select falling edge.
    // Edges outside a frame are ignored, so stray clocks never advance it.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            edgeCnt_reg <= sacp_pkg::EDGE_ZERO;
        end else if (csFall) begin
            edgeCnt_reg <= sacp_pkg::EDGE_ZERO;
        end else if (inFrame && sclkFall) begin
            edgeCnt_reg <= edgeCnt_reg + sacp_pkg::EDGE_ONE;
        end
    end

    // Shift register: MSB is the pin; load on select, shift on falling edges.
    // An empty buffer loads zeros, so a frame without a sample reads as zero.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_reg <= sacp_pkg::WORD_ZERO;
        end else if (csFall) begin
            shift_reg <= fifoValid ? wordLoad : sacp_pkg::WORD_ZERO;
        end else if (inFrame && sclkFall) begin
            shift_reg <= {shift_reg[NEXT_MSB:0], 1'b0};
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    // All outputs leave through flops so the pins see no decode glitches;
    // the price is one system clock of delay behind the detected edge.
    // Output enable follows the next state so it drops on the ending edge.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            serialResultOut <= 1'b0;
            serialResultOeN <= 1'b1;
            trackMode <= 1'b0;
            poweredUp <= 1'b0;
            frameDone <= 1'b0;
        end else begin
            // The pin takes the shifter's next MSB so both move in the same cycle.
            serialResultOut <= csFall ? (fifoValid ? wordLoad[WORD_MSB] : 1'b0) :
                               (inFrame && sclkFall) ? shift_reg[NEXT_MSB] : shift_reg[WORD_MSB];
            serialResultOeN <= (state_next == sacp_pkg::ST_POWER_DOWN);
            trackMode <= (state_next == sacp_pkg::ST_TRACK);
            poweredUp <= (state_next != sacp_pkg::ST_POWER_DOWN);
            // Only a completed frame is marked; an abort on the same edge wins.
            frameDone <= (state_reg == sacp_pkg::ST_CONVERT) && !csRise && lastEdge;
        end
    end
endmodule : sacp_sequencer

/* File: tb/sacp_seq_sva.sv */
// Concurrent checks on the pins of the converter sequencer.
`timescale 1ns/100ps
module sacp_seq_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Watched ports
    input wire logic [1:0] variantSel,
    input wire logic chipSelectN,
    input wire logic serialClk,
    input wire logic serialResultOut,
    input wire logic serialResultOeN,
    input wire logic trackMode,
    input wire logic poweredUp,
    input wire logic frameDone
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic [4:0] fallCnt_reg;
    // Index of the last counted falling edge for the strapped variant.
    wire logic [4:0] lastIdx = (variantSel == 2'h1) ? 5'h0d : (variantSel == 2'h2) ? 5'h0b : 5'h0f;
    // Raw pin edges are counted here, so a slip in the design's own counter shows up.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fallCnt_reg <= 5'h00;
        end else if ($fell(chipSelectN)) begin
            fallCnt_reg <= 5'h00;
        end else if ($fell(serialClk) && !chipSelectN) begin
            fallCnt_reg <= fallCnt_reg + 5'h01;
        end
    end
    sequence s_idle;
        serialResultOeN && !poweredUp && !trackMode;
    endsequence
    sequence s_start;
        !serialResultOeN && trackMode && poweredUp && !serialResultOut;
    endsequence
    sequence s_fall;
        $fell(serialClk) && !chipSelectN;
    endsequence
    property p_cs_fall;
        $fell(chipSelectN) |-> ##[2:6] s_start;
    endproperty
    property p_cs_rise;
        $rose(chipSelectN) |-> ##[2:6] s_idle;
    endproperty
    property p_hold_pd;
        !poweredUp |-> !trackMode;
    endproperty
    property p_oe_pwr;
        poweredUp == !serialResultOeN;
    endproperty
    property p_oe_desel;
        chipSelectN [*5] |-> serialResultOeN;
    endproperty
    property p_done_idle;
        frameDone |-> s_idle;
    endproperty
    property p_done_pulse;
        frameDone |=> !frameDone;
    endproperty
    property p_third;
        s_fall ##0 (fallCnt_reg == 5'h02) |-> ##[2:6] !trackMode;
    endproperty
    property p_last;
        s_fall ##0 (fallCnt_reg == lastIdx) |-> ##[2:6] (frameDone && serialResultOeN);
    endproperty
    property p_lead;
        s_fall ##0 (fallCnt_reg < 5'h03) |-> ##[3:5] (!serialResultOut && !serialResultOeN);
    endproperty
    a_cs_fall: assert property (p_cs_fall) else $error("select fall did not start a frame");
    a_cs_rise: assert property (p_cs_rise) else $error("select rise did not power down");
    a_hold_pd: assert property (p_hold_pd) else $error("tracking while powered down");
    a_oe_pwr: assert property (p_oe_pwr) else $error("output enabled outside a frame");
    a_oe_desel: assert property (p_oe_desel) else $error("output enabled while deselected");
    a_done_idle: assert property (p_done_idle) else $error("frame end without power-down");
    a_done_pulse: assert property (p_done_pulse) else $error("frame end pulse too long");
    a_third: assert property (p_third) else $error("no hold after third falling edge");
    a_last: assert property (p_last) else $error("no frame end on last edge");
    a_lead: assert property (p_lead) else $error("leading zero missing");
endmodule : sacp_seq_sva

/* File: tb/sacp_master.sv */
// Serial-port master that frames conversions and shifts in the result.
`timescale 1ns/100ps
module sacp_master (
    // Clock
    input wire logic clk,
    // Serial link pins
    output logic chipSelectN,
    output logic serialClk,
    input wire logic serialResultOut,
    input wire logic serialResultOeN
);
    logic lastBit;
    // A released line shows the inverse of its last value, so stale bits never pass.
    wire logic pinLevel = serialResultOeN ? ~lastBit : serialResultOut;
    initial begin
        chipSelectN = 1'b1;
        serialClk = 1'b0;
        lastBit = 1'b0;
    end
    always @(posedge clk) begin
        if (serialResultOeN === 1'b0) begin
            lastBit <= serialResultOut;
        end
    end
    // Half of the 160 ns link period.
    task half;
        repeat (16) @(posedge clk);
    endtask : half
    // The clock stands still outside frames; bits are taken on rising edges.
    task frame(input int falls, output logic [15:0] word);
        word = 16'h0000;
        @(posedge clk);
        chipSelectN <= 1'b0;
        half();
        for (int k = 0; k < falls; k++) begin
            serialClk <= 1'b1;
            word = {word[14:0], pinLevel};
            half();
            serialClk <= 1'b0;
            half();
        end
        chipSelectN <= 1'b1;
        half();
        half();
    endtask : frame
    // Clock edges with select high, which the device must ignore.
    task stray;
        for (int k = 0; k < 4; k++) begin
            serialClk <= 1'b1;
            half();
            serialClk <= 1'b0;
            half();
        end
    endtask : stray
endmodule : sacp_master

/* File: tb/testbench.sv */
// Self-checking bench of the converter sequencer.
`timescale 1ns/100ps
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] variantSel = 2'h0;
    logic sampleValid = 1'b0;
    logic [11:0] sampleData = 12'h000;
    logic sampleReady, chipSelectN, serialClk, serialResultOut, serialResultOeN, trackMode, poweredUp, frameDone;
    logic [15:0] w;
    int n_fail = 0;
    int num_checks = 0;
    int doneCount = 0;
    always #2.5 clk = ~clk;
    always @(posedge clk) if (frameDone === 1'b1) doneCount <= doneCount + 1;
    sacp_sequencer i_dut (.clk(clk), .rst(rst), .variantSel(variantSel), .sampleValid(sampleValid),
        .sampleReady(sampleReady), .sampleData(sampleData), .chipSelectN(chipSelectN), .serialClk(serialClk),
        .serialResultOut(serialResultOut), .serialResultOeN(serialResultOeN), .trackMode(trackMode),
        .poweredUp(poweredUp), .frameDone(frameDone));
    sacp_master i_master (.clk(clk), .chipSelectN(chipSelectN), .serialClk(serialClk),
        .serialResultOut(serialResultOut), .serialResultOeN(serialResultOeN));
    function automatic logic [11:0] dat(input int i);
        return 12'h8a5 ^ 12'(i * 12'h1f3);
    endfunction : dat
    function automatic int edges(input logic [1:0] v);
        return (v == sacp_pkg::VAR_10) ? 14 : (v == sacp_pkg::VAR_8) ? 12 : 16;
    endfunction : edges
    // Narrow variants keep only their low result bits behind the four zeros.
    function automatic logic [15:0] expw(input logic [1:0] v, input logic [11:0] d);
        return (v == sacp_pkg::VAR_10) ? {6'h00, d[9:0]} : (v == sacp_pkg::VAR_8) ? {8'h00, d[7:0]} : {4'h0, d};
    endfunction : expw
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop
    // Nine offers back to back; the ninth must be refused by a full buffer.
    task test_fill;
        for (int i = 0; i < 9; i++) begin
            @(posedge clk);
            sampleValid <= 1'b1;
            sampleData <= dat(i);
        end
        @(posedge clk);
        sampleValid <= 1'b0;
        #1 check("ready", 16'h0000, {15'h0000, sampleReady});
    endtask : test_fill
    // Dummy frame after power-up; the empty buffer must read as all zeros.
    task test_dummy;
        i_master.frame(16, w);
        check("dummy word", 16'h0000, w);
    endtask : test_dummy
    // Drain all eight words across the variants, strap value three acting as 12 bits,
    // then one frame from the empty buffer.
    task test_drain;
        int d0;
        for (int i = 0; i < 9; i++) begin
            @(posedge clk);
            variantSel <= 2'(i % 4);
            d0 = doneCount;
            i_master.frame(edges(2'(i % 4)), w);
            check("word", (i < 8) ? expw(2'(i % 4), dat(i)) : 16'h0000, w);
            check("done", 16'(d0 + 1), 16'(doneCount));
        end
        check("ready", 16'h0001, {15'h0000, sampleReady});
    endtask : test_drain
    // Abort after five edges, stray edges while idle, then a clean frame.
    task test_abort;
        int d0;
        @(posedge clk);
        variantSel <= sacp_pkg::VAR_12;
        sampleValid <= 1'b1;
        sampleData <= 12'h9a5;
        @(posedge clk);
        sampleData <= 12'h5c3;
        @(posedge clk);
        sampleValid <= 1'b0;
        d0 = doneCount;
        i_master.frame(5, w);
        check("abort word", 16'h0001, w);
        check("abort done", 16'(d0), 16'(doneCount));
        check("abort state", 16'h0002, {13'h0000, trackMode, serialResultOeN, poweredUp});
        i_master.stray();
        check("stray state", 16'h0002, {13'h0000, trackMode, serialResultOeN, poweredUp});
        i_master.frame(16, w);
        check("after abort", 16'h05c3, w);
    endtask : test_abort
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        test_dummy();
        test_fill();
        test_drain();
        test_abort();
        report_and_stop();
    end
    initial begin
        #200000;
        n_fail++;
        report_and_stop();
    end
endmodule : testbench
bind sacp_sequencer sacp_seq_sva i_sva (.clk(clk), .rst(rst), .variantSel(variantSel), .chipSelectN(chipSelectN),
    .serialClk(serialClk), .serialResultOut(serialResultOut), .serialResultOeN(serialResultOeN),
    .trackMode(trackMode), .poweredUp(poweredUp), .frameDone(frameDone));
